// file: logic/prbs_tally_pkg.sv
// package: register map, field positions and types of the checker counters
package prbs_tally_pkg;

  // ---------------------------------------------------------------
  // register indices as printed, byte address is four times these
  // ---------------------------------------------------------------
  localparam logic [7:0]  IDX_BYTE_TOTAL     = 8'h71;
  localparam logic [7:0]  IDX_COUNTER_STATUS = 8'h72;
  localparam logic [7:0]  IDX_IRQ_STATUS     = 8'h80;
  localparam logic [7:0]  IDX_IRQ_MASK       = 8'h81;
  localparam logic [7:0]  IDX_MODE_CTRL      = 8'h82;
  localparam logic [11:0] ADDR_BYTE_TOTAL     = {2'h0, IDX_BYTE_TOTAL, 2'h0};
  localparam logic [11:0] ADDR_COUNTER_STATUS = {2'h0, IDX_COUNTER_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS     = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK       = {2'h0, IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] ADDR_MODE_CTRL      = {2'h0, IDX_MODE_CTRL, 2'h0};

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          BIT_LOCK        = 0;
  localparam int          BIT_LOCK_CLEAR  = 1;
  localparam int          BIT_BYTE_OVF    = 9;
  localparam int          BIT_PKT_OVF     = 10;
  localparam int          BYTE_W          = 16;
  localparam int          ERR_W           = 8;
  localparam int          PKT_W           = 16;
  localparam logic [15:0] RST_BYTE_TOTAL  = 16'h0000;
  localparam logic [7:0]  RST_ERR_TALLY   = 8'h00;
  localparam int          IRQ_W           = 3;
  localparam int          IRQ_BYTE_OVF    = 0;
  localparam int          IRQ_PKT_OVF     = 1;
  localparam int          IRQ_ERR_FULL    = 2;
  localparam logic [2:0]  RST_IRQ         = 3'h0;
  localparam logic        RST_SAT_MODE    = 1'b0;

  // checker events from the receive path
  typedef struct packed {
    logic byte_ok;
    logic byte_err;
    logic pkt_done;
  } rx_event_t;

  // tally values held in the locked snapshot of the register file
  typedef struct packed {
    logic [15:0] bytes;
    logic [7:0]  errs;
    logic        byte_ovf;
    logic        pkt_ovf;
  } tally_t;

endpackage : prbs_tally_pkg

// file: logic/prbs_tally_counter.sv
// saturating or wrapping counter with overflow flag
`timescale 1ns/1ps
`default_nettype none
module prbs_tally_counter #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         inc,
  input  wire logic         clr,
  input  wire logic         wrap_mode,
  output var  logic [W-1:0] count_ff,
  output var  logic         ovf_ff
);

  if (W < 2) begin : g_bad_width
    $error("counter width too small");
  end

  logic [W-1:0] nxt_count;
  logic         at_max;

  assign at_max = &count_ff;

  always_comb begin
    nxt_count = count_ff;
    if (clr) begin
      nxt_count = '0;
    end else if (inc && (!at_max || wrap_mode)) begin
      nxt_count = count_ff + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // overflow is sticky until the counters are cleared
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovf_ff <= 1'b0;
    end else if (clr) begin
      ovf_ff <= 1'b0;
    end else if (inc && at_max) begin
      ovf_ff <= 1'b1;
    end
  end

endmodule : prbs_tally_counter
`default_nettype wire

// file: logic/prbs_checker_counters.sv
// checker statistics counters with apb register file and interrupt
// How it works
// - A 16-bit read-only total of received bytes, zero after reset.
// - The readable byte total is frozen whenever either trigger bit is written.
// - With saturate mode zero the byte total stops at its maximum.
// - Bit 10 reports, read-only, that the packet counter overflowed.
// - Bit 9 reports, read-only, that the byte counter overflowed.
// - Both overflow flags clear only when the counters are cleared by trigger bit 1.
// - An 8-bit read-only tally of errored bytes at bits 7:0, zero after reset.
// - With saturate mode zero the error tally stops at its maximum.
// - Writing trigger bit 0 locks the readable counter values without clearing.
// - Writing trigger bit 1 locks the values and then zeroes the counters.
`timescale 1ns/1ps
`default_nettype none
module prbs_checker_counters
  import prbs_tally_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire rx_event_t   rx_event,
  output var  logic        irq
);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic        setup;
  logic        wr_now;
  logic        rd_now;
  logic        hit;
  logic        lock_pulse;
  logic        clear_pulse;
  logic        wr_lane0;

  assign setup    = psel && !penable;
  assign wr_now   = psel && penable && pready && pwrite;
  assign rd_now   = setup && !pwrite;
  assign wr_lane0 = pstrb[0];
  assign hit      = (paddr == ADDR_BYTE_TOTAL) || (paddr == ADDR_COUNTER_STATUS) ||
                    (paddr == ADDR_IRQ_STATUS) || (paddr == ADDR_IRQ_MASK) ||
                    (paddr == ADDR_MODE_CTRL);

  // trigger strobes from a write to the status register
  assign lock_pulse  = wr_now && wr_lane0 && (paddr == ADDR_COUNTER_STATUS) &&
                       (pwdata[BIT_LOCK] || pwdata[BIT_LOCK_CLEAR]);
  assign clear_pulse = wr_now && wr_lane0 && (paddr == ADDR_COUNTER_STATUS) &&
                       pwdata[BIT_LOCK_CLEAR];

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic             sat_mode_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] irq_stat_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sat_mode_ff <= RST_SAT_MODE;
    end else if (wr_now && wr_lane0 && paddr == ADDR_MODE_CTRL) begin
      sat_mode_ff <= pwdata[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_mask_ff <= RST_IRQ;
    end else if (wr_now && wr_lane0 && paddr == ADDR_IRQ_MASK) begin
      irq_mask_ff <= pwdata[IRQ_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // live counters
  // ---------------------------------------------------------------
  logic [BYTE_W-1:0] byte_cnt;
  logic [ERR_W-1:0]  err_cnt;
  logic [PKT_W-1:0]  pkt_cnt;
  logic              byte_ovf;
  logic              err_ovf;
  logic              pkt_ovf;

  prbs_tally_counter #(.W(BYTE_W)) u_byte_cnt (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .inc       (rx_event.byte_ok || rx_event.byte_err),
    .clr       (clear_pulse),
    .wrap_mode (sat_mode_ff),
    .count_ff  (byte_cnt),
    .ovf_ff    (byte_ovf)
  );

  prbs_tally_counter #(.W(ERR_W)) u_err_cnt (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .inc       (rx_event.byte_err),
    .clr       (clear_pulse),
    .wrap_mode (sat_mode_ff),
    .count_ff  (err_cnt),
    .ovf_ff    (err_ovf)
  );

  prbs_tally_counter #(.W(PKT_W)) u_pkt_cnt (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .inc       (rx_event.pkt_done),
    .clr       (clear_pulse),
    .wrap_mode (1'b1),
    .count_ff  (pkt_cnt),
    .ovf_ff    (pkt_ovf)
  );

  // ---------------------------------------------------------------
  // locked snapshot, taken before the clear lands
  // ---------------------------------------------------------------
  tally_t snap_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      snap_ff <= '{bytes: RST_BYTE_TOTAL, errs: RST_ERR_TALLY, byte_ovf: 1'b0, pkt_ovf: 1'b0};
    end else if (lock_pulse) begin
      snap_ff.bytes <= byte_cnt;
      snap_ff.errs  <= err_cnt;
    end
    if (!rst) begin
      snap_ff.byte_ovf <= byte_ovf && !clear_pulse;
      snap_ff.pkt_ovf  <= pkt_ovf && !clear_pulse;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, set wins over write-one-to-clear
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic             byte_ovf_d_ff;
  logic             pkt_ovf_d_ff;
  logic             err_ovf_d_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      byte_ovf_d_ff <= 1'b0;
      pkt_ovf_d_ff  <= 1'b0;
      err_ovf_d_ff  <= 1'b0;
    end else begin
      byte_ovf_d_ff <= byte_ovf;
      pkt_ovf_d_ff  <= pkt_ovf;
      err_ovf_d_ff  <= err_ovf;
    end
  end

  assign irq_set[IRQ_BYTE_OVF] = byte_ovf && !byte_ovf_d_ff;
  assign irq_set[IRQ_PKT_OVF]  = pkt_ovf && !pkt_ovf_d_ff;
  assign irq_set[IRQ_ERR_FULL] = err_ovf && !err_ovf_d_ff;
  assign irq_clr = (wr_now && wr_lane0 && paddr == ADDR_IRQ_STATUS) ?
                   pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_ff <= RST_IRQ;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_mask_ff);
    end
  end

  // ---------------------------------------------------------------
  // apb answer: no wait states, read data registered in setup
  // ---------------------------------------------------------------
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    case (paddr)
      ADDR_BYTE_TOTAL:     nxt_rdata[BYTE_W-1:0] = snap_ff.bytes;
      ADDR_COUNTER_STATUS: begin
        nxt_rdata[BIT_PKT_OVF]  = snap_ff.pkt_ovf;
        nxt_rdata[BIT_BYTE_OVF] = snap_ff.byte_ovf;
        nxt_rdata[ERR_W-1:0]    = snap_ff.errs;
      end
      ADDR_IRQ_STATUS:     nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
      ADDR_IRQ_MASK:       nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
      ADDR_MODE_CTRL:      nxt_rdata[0] = sat_mode_ff;
      default:             nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      if (rd_now) begin
        prdata <= nxt_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_byte_saturate: assert property (@(posedge sys_clk) disable iff (rst)
    (!sat_mode_ff && byte_cnt == 16'hffff && !clear_pulse) |=> byte_cnt == 16'hffff)
    else $error("byte total left its maximum in saturate mode");

  a_err_saturate: assert property (@(posedge sys_clk) disable iff (rst)
    (!sat_mode_ff && err_cnt == 8'hff && !clear_pulse) |=> err_cnt == 8'hff)
    else $error("error tally left its maximum in saturate mode");

  a_byte_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    (sat_mode_ff && byte_cnt == 16'hffff && rx_event.byte_ok && !clear_pulse)
    |=> byte_cnt == 16'h0000 && byte_ovf ##1 (snap_ff.byte_ovf || $past(clear_pulse)))
    else $error("byte total did not wrap with overflow");

  a_err_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    (sat_mode_ff && err_cnt == 8'hff && rx_event.byte_err && !clear_pulse)
    |=> err_cnt == 8'h00 && err_ovf)
    else $error("error tally did not wrap with overflow");

  a_clear_zeroes: assert property (@(posedge sys_clk) disable iff (rst)
    clear_pulse |=> byte_cnt == 16'h0000 && err_cnt == 8'h00 && !byte_ovf && !pkt_ovf)
    else $error("clear left counters nonzero");

  a_clear_flags: assert property (@(posedge sys_clk) disable iff (rst)
    clear_pulse |=> !snap_ff.byte_ovf && !snap_ff.pkt_ovf)
    else $error("clear left overflow flags set");

  a_ovf_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    (byte_ovf && !clear_pulse) |=> byte_ovf)
    else $error("byte overflow dropped without clear");

  a_pkt_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    (pkt_ovf && !clear_pulse) |=> pkt_ovf)
    else $error("packet overflow dropped without clear");

  a_byte_ovf_set: assert property (@(posedge sys_clk) disable iff (rst)
    (byte_cnt == 16'hffff && (rx_event.byte_ok || rx_event.byte_err) && !clear_pulse)
    |=> byte_ovf)
    else $error("byte overflow not raised at the maximum");

  a_pkt_ovf_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (pkt_ovf && !clear_pulse) |=> snap_ff.pkt_ovf)
    else $error("packet overflow not reported");

  a_lock_capture: assert property (@(posedge sys_clk) disable iff (rst)
    lock_pulse |=> snap_ff.bytes == $past(byte_cnt) && snap_ff.errs == $past(err_cnt))
    else $error("lock did not capture counters");

  a_lock_holds: assert property (@(posedge sys_clk) disable iff (rst)
    !lock_pulse |=> $stable(snap_ff.bytes) && $stable(snap_ff.errs))
    else $error("locked value changed without trigger");

  a_byte_count: assert property (@(posedge sys_clk) disable iff (rst)
    (rx_event.byte_ok && !clear_pulse && byte_cnt != 16'hffff)
    |=> byte_cnt == $past(byte_cnt) + 16'h0001)
    else $error("byte total missed a byte");

  a_err_count: assert property (@(posedge sys_clk) disable iff (rst)
    (rx_event.byte_err && !clear_pulse && err_cnt != 8'hff)
    |=> err_cnt == $past(err_cnt) + 8'h01)
    else $error("error tally missed a byte");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_now && paddr == ADDR_COUNTER_STATUS) |=> prdata[31:11] == '0 && !prdata[8])
    else $error("reserved status bits not zero");

  a_byte_ovf_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (byte_ovf && !clear_pulse) |=> snap_ff.byte_ovf)
    else $error("byte overflow not reported");

  a_mode_strobe: assert property (@(posedge sys_clk) disable iff (rst)
    (psel && penable && pwrite && !pstrb[0] && paddr == ADDR_MODE_CTRL)
    |=> $stable(sat_mode_ff))
    else $error("mode changed on a masked byte lane");

  a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(irq_mask_ff) |-> irq == |(irq_stat_ff & irq_mask_ff))
    else $error("interrupt output disagrees with status and mask");

  a_pready_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !rd_now |=> $stable(prdata))
    else $error("read data changed without a read");

endmodule : prbs_checker_counters
`default_nettype wire

// file: verif/tb_prbs_checker_counters.sv
// self-checking testbench for the checker statistics counters
`timescale 1ns/1ps
`default_nettype none
module tb_prbs_checker_counters
  import prbs_tally_pkg::*;
;
  // ------------------------------------------------------------
  // signals and design instance
  // ------------------------------------------------------------
  logic        sys_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  rx_event_t   rx_event;
  logic        irq;
  logic [31:0] rdata;
  logic        rerr;
  int          miscompares;
  int          total_checks;

  prbs_checker_counters u_prbs_checker_counters (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .pstrb    (pstrb),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .rx_event (rx_event),
    .irq      (irq)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer, entered just after an edge, left at the sampling edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("[ERR] pready expected 1 seen %b", pready);
      report_and_stop();
    end else begin
      rdata   = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(nm, exp, rdata);
  endtask : rdchk

  // holds the event pattern for n counting edges
  task automatic pulse(input rx_event_t v, input int n);
    repeat (n) begin
      rx_event <= v;
      @(posedge sys_clk);
    end
    rx_event <= '0;
    @(posedge sys_clk);
  endtask : pulse

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    miscompares  = 0;
    total_checks = 0;
    rst      = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    pstrb    = 4'h0;
    rx_event = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rdchk("byte_total_rst", ADDR_BYTE_TOTAL, 32'h0000_0000);
    rdchk("status_rst", ADDR_COUNTER_STATUS, 32'h0000_0000);
    rdchk("mask_rst", ADDR_IRQ_MASK, 32'h0000_0000);
    rdchk("mode_rst", ADDR_MODE_CTRL, 32'h0000_0000);
    rdchk("unmapped_data", 12'h000, 32'h0000_0000);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    // masked-off byte lane leaves the mode alone
    apb(1'b1, ADDR_MODE_CTRL, 32'h0000_0001, 4'he);
    rdchk("mode_strb", ADDR_MODE_CTRL, 32'h0000_0000);
    // saturate mode: 65537 bytes and packets, last 258 bytes errored
    pulse(3'b101, 65279);
    pulse(3'b111, 258);
    repeat (3) @(posedge sys_clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdchk("irq_status", ADDR_IRQ_STATUS, 32'h0000_0007);
    rdchk("status_ovf", ADDR_COUNTER_STATUS, 32'h0000_0600);
    wr(ADDR_COUNTER_STATUS, 32'h0000_0001);
    rdchk("total_sat", ADDR_BYTE_TOTAL, 32'h0000_ffff);
    rdchk("status_sat", ADDR_COUNTER_STATUS, 32'h0000_06ff);
    // wrap mode: three errored bytes roll both counters over
    wr(ADDR_MODE_CTRL, 32'h0000_0001);
    rdchk("mode_wrap", ADDR_MODE_CTRL, 32'h0000_0001);
    pulse(3'b110, 3);
    wr(ADDR_COUNTER_STATUS, 32'h0000_0001);
    rdchk("total_wrap", ADDR_BYTE_TOTAL, 32'h0000_0002);
    rdchk("status_lock", ADDR_COUNTER_STATUS, 32'h0000_0602);
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_STATUS, 32'h0000_0007);
    repeat (2) @(posedge sys_clk);
    chk("irq_off", 32'h0, {31'h0, irq});
    rdchk("irq_cleared", ADDR_IRQ_STATUS, 32'h0000_0000);
    // live count runs on behind the frozen snapshot
    pulse(3'b100, 5);
    rdchk("total_frozen", ADDR_BYTE_TOTAL, 32'h0000_0002);
    wr(ADDR_COUNTER_STATUS, 32'h0000_fd02);
    repeat (2) @(posedge sys_clk);
    rdchk("total_clr_snap", ADDR_BYTE_TOTAL, 32'h0000_0007);
    rdchk("status_clr", ADDR_COUNTER_STATUS, 32'h0000_0002);
    wr(ADDR_COUNTER_STATUS, 32'h0000_0001);
    rdchk("total_zero", ADDR_BYTE_TOTAL, 32'h0000_0000);
    rdchk("status_zero", ADDR_COUNTER_STATUS, 32'h0000_0000);
    // saturate mode: errored bytes count as bytes, tally sticks at its maximum
    wr(ADDR_MODE_CTRL, 32'h0000_0000);
    pulse(3'b010, 300);
    wr(ADDR_COUNTER_STATUS, 32'h0000_0001);
    rdchk("total_err_bytes", ADDR_BYTE_TOTAL, 32'h0000_012c);
    rdchk("err_sat", ADDR_COUNTER_STATUS, 32'h0000_00ff);
    rdchk("irq_err_full", ADDR_IRQ_STATUS, 32'h0000_0004);
    report_and_stop();
  end

endmodule : tb_prbs_checker_counters
`default_nettype wire
